// >>> bpo_pkg.sv
// Constants, register map and state types for the bidirectional port block.
// Assumes a 32-bit AXI4-Lite register bus, with registers in the low byte lanes.
package bpo_pkg;

    localparam int unsigned PORT_W = 8;

    // Register byte offsets
    localparam logic [7:0] OFF_D_DATA = 8'h00;
    localparam logic [7:0] OFF_D_DIR  = 8'h04;
    localparam logic [7:0] OFF_D_LAT  = 8'h08;
    localparam logic [7:0] OFF_C_DATA = 8'h0C;
    localparam logic [7:0] OFF_C_DIR  = 8'h10;
    localparam logic [7:0] OFF_C_LAT  = 8'h14;
    localparam logic [7:0] OFF_E_DIR  = 8'h18;
    localparam logic [7:0] OFF_CFG    = 8'h1C;
    localparam logic [7:0] OFF_STAT   = 8'h20;

    // Reset values
    localparam logic [7:0] RST_DIR   = 8'hFF;
    localparam logic [7:0] RST_LAT   = 8'h00;
    localparam logic [7:0] RST_E_DIR = 8'h00;
    localparam logic [7:0] RST_CFG   = 8'h01;

    // Field positions
    localparam int unsigned PSP_EN_BIT    = 4;
    localparam int unsigned CFG_SECOND_CAPTURE_COMPARE_BIT  = 0;
    localparam int unsigned STAT_PSP_BIT  = 0;
    localparam int unsigned STAT_TTL_BIT  = 1;
    localparam int unsigned STAT_SMB_BIT  = 2;

    // Pin positions
    localparam int unsigned PD_PWM_B = 5;
    localparam int unsigned PD_PWM_C = 6;
    localparam int unsigned PD_PWM_D = 7;
    localparam int unsigned PC_SECOND_CAPTURE_COMPARE  = 1;
    localparam int unsigned PC_CCP1  = 2;
    localparam int unsigned PC_SCK   = 3;
    localparam int unsigned PC_SDA   = 4;
    localparam int unsigned PC_SDO   = 5;
    localparam int unsigned PC_TX    = 6;
    localparam int unsigned PC_RX    = 7;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        EPWM_SINGLE   = 2'h0,
        EPWM_HALF     = 2'h1,
        EPWM_FULL_FWD = 2'h2,
        EPWM_FULL_REV = 2'h3
    } bpo_epwm_e;

    typedef struct packed {
        logic        awh;
        logic        wh;
        logic [7:0]  awaddr;
        logic        awbad;
        logic [7:0]  wdata;
        logic        wstrb0;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [7:0]  d_dir;
        logic [7:0]  d_lat;
        logic [7:0]  c_dir;
        logic [7:0]  c_lat;
        logic [7:0]  e_dir;
        logic [7:0]  cfg;
    } bpo_regs_s;

    localparam bpo_regs_s REGS_RST = '{
        awh: 1'b0, wh: 1'b0, awaddr: 8'h00, awbad: 1'b0, wdata: 8'h00, wstrb0: 1'b0,
        bvalid: 1'b0, bresp: RESP_OKAY, rvalid: 1'b0, rdata: 32'h00000000, rresp: RESP_OKAY,
        d_dir: RST_DIR, d_lat: RST_LAT, c_dir: RST_DIR, c_lat: RST_LAT,
        e_dir: RST_E_DIR, cfg: RST_CFG
    };

    typedef struct packed {
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [7:0] pad_out;
        logic [7:0] pad_oe_n;
    } bpo_mux_s;

    localparam bpo_mux_s MUX_RST = '{
        sync1: 8'h00, sync2: 8'h00, pad_out: 8'h00, pad_oe_n: 8'hFF
    };

endpackage : bpo_pkg

// >>> bpo_pin_if.sv
// Carrier between the port top and one 8-bit pin multiplexer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface bpo_pin_if;
    logic [7:0] tris;
    logic [7:0] latch;
    logic [7:0] ovr_dir_en;
    logic [7:0] ovr_dir;
    logic [7:0] ovr_data_en;
    logic [7:0] ovr_data;
    logic [7:0] pad_out;
    logic [7:0] pad_oe_n;
    logic [7:0] level;

    modport mux (
        input  tris,
        input  latch,
        input  ovr_dir_en,
        input  ovr_dir,
        input  ovr_data_en,
        input  ovr_data,
        output pad_out,
        output pad_oe_n,
        output level
    );

    modport ctrl (
        output tris,
        output latch,
        output ovr_dir_en,
        output ovr_dir,
        output ovr_data_en,
        output ovr_data,
        input  pad_out,
        input  pad_oe_n,
        input  level
    );
endinterface : bpo_pin_if

// >>> bpo_pin_mux.sv
// One 8-bit pin multiplexer: direction and data selection plus input synchroniser.
// Assumes raw pad levels arrive asynchronously; overrides come from aclk logic.
`timescale 1ns/1ps
module bpo_pin_mux
    import bpo_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [7:0] pin_in,
    bpo_pin_if.mux          pins
);

    bpo_mux_s   st_r;
    bpo_mux_s   st_nxt;
    logic [7:0] dir_sel;
    logic [7:0] val_sel;

    genvar gi;
    generate
        for (gi = 0; gi < PORT_W; gi++) begin : g_bit
            // Peripheral owning the direction ignores the direction bit
            assign dir_sel[gi] = pins.ovr_dir_en[gi] ? pins.ovr_dir[gi] : pins.tris[gi];
            assign val_sel[gi] = pins.ovr_data_en[gi] ? pins.ovr_data[gi] : pins.latch[gi];
        end
    endgenerate

    always_comb begin
        st_nxt          = st_r;
        st_nxt.sync1    = pin_in;
        st_nxt.sync2    = st_r.sync1;
        st_nxt.pad_out  = val_sel;
        // Direction 1 leaves the driver off, direction 0 drives
        st_nxt.pad_oe_n = dir_sel;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= MUX_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pins.pad_out  = st_r.pad_out;
    assign pins.pad_oe_n = st_r.pad_oe_n;
    // Levels are read regardless of direction
    assign pins.level    = st_r.sync2;

endmodule : bpo_pin_mux

// >>> bpo_port_top.sv
// Bidirectional 8-bit port with peripheral overrides, plus the shared third port.
// Assumes AXI4-Lite master on aclk; peripheral controls are synchronous to aclk.
// Contract
// - Fourth port: eight pins, per-pin direction
// - Direction one puts pin driver hi-z
// - Direction zero drives latch bit out
// - Latch readable; RMW sees latch, not pins
// - Normal mode uses Schmitt input buffers
// - PWM B, C, D take over pins
// - Reset makes all pins digital inputs
// - Enable bit four makes parallel slave
// - Parallel slave uses TTL input buffers
// - Dual or quad PWM disables parallel slave
// - Serial module output overrides latch data
// - I2C data buffer type set by module
// - Sync master drives clock, slave inputs
// - Receive data through Schmitt input
// - Peripheral-owned direction ignores direction bit
// - Capture two pin chosen by select
// - Direction reads return stored bits
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module bpo_port_top
    import bpo_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  pd_in,
    output logic [7:0]       pd_out,
    output logic [7:0]       pd_oe_n,
    input  wire logic [7:0]  pc_in,
    output logic [7:0]       pc_out,
    output logic [7:0]       pc_oe_n,
    input  wire logic        alt_pin_port_b_bit3_in,
    output logic             alt_pin_port_b_bit3_out,
    output logic             alt_pin_port_b_bit3_oe_n,
    input  wire logic [1:0]  epwm_mode,
    input  wire logic        epwm_shutdown_tristate,
    input  wire logic        enhanced_pwm_out_b,
    input  wire logic        enhanced_pwm_out_c,
    input  wire logic        enhanced_pwm_out_d,
    input  wire logic        psp_read_drive,
    output logic [7:0]       psp_write_data,
    output logic             psp_active,
    output logic             fourth_port_ttl_sel,
    input  wire logic        ssp_spi_en,
    input  wire logic        ssp_sck_master,
    input  wire logic        ssp_sck_out,
    input  wire logic        ssp_sdo,
    input  wire logic        ssp_i2c_en,
    input  wire logic        ssp_scl_low,
    input  wire logic        ssp_sda_low,
    input  wire logic        ssp_i2c_smbus_levels,
    output logic             ssp_sck_in,
    output logic             ssp_sdi,
    output logic             i2c_sda_smbus_buf,
    input  wire logic        usart_en,
    input  wire logic        usart_sync,
    input  wire logic        usart_sync_master,
    input  wire logic        usart_tx,
    input  wire logic        usart_sync_clock_out,
    input  wire logic        usart_sync_data_out,
    input  wire logic        usart_sync_data_drive,
    output logic             usart_rx_in,
    output logic             usart_sync_clock_in,
    input  wire logic        ccp1_out_en,
    input  wire logic        ccp1_out,
    input  wire logic        second_capture_compare_out_en,
    input  wire logic        second_capture_compare_out,
    output logic             ccp1_in,
    output logic             second_capture_compare_in
);

    bpo_regs_s  r;
    bpo_regs_s  n;
    logic [1:0] alt_sync_r;
    logic       second_capture_compare_sel;
    logic       pwm_b_en;
    logic       pwm_cd_en;
    logic [7:0] d_level;
    logic [7:0] c_level;

    bpo_pin_if  d_if ();
    bpo_pin_if  c_if ();

    bpo_pin_mux u_port_d (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin_in  (pd_in),
        .pins    (d_if.mux)
    );

    bpo_pin_mux u_port_c (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin_in  (pc_in),
        .pins    (c_if.mux)
    );

    assign d_level = d_if.level;
    assign c_level = c_if.level;

    // Fourth port overrides
    assign pwm_b_en   = (epwm_mode != EPWM_SINGLE);
    assign pwm_cd_en  = (epwm_mode == EPWM_FULL_FWD) || (epwm_mode == EPWM_FULL_REV);
    // Any multi-output PWM mode wins over the slave enable
    assign psp_active = r.e_dir[PSP_EN_BIT] && (epwm_mode == EPWM_SINGLE);
    assign fourth_port_ttl_sel = psp_active;
    assign psp_write_data      = d_level;

    always_comb begin
        d_if.tris        = r.d_dir;
        d_if.latch       = r.d_lat;
        // Parallel slave drives latch on reads, otherwise listens
        d_if.ovr_dir_en  = {8{psp_active}};
        d_if.ovr_dir     = {8{~psp_read_drive}};
        d_if.ovr_data_en = 8'h00;
        d_if.ovr_data    = r.d_lat;
        if (pwm_b_en) begin
            d_if.ovr_data_en[PD_PWM_B] = 1'b1;
            d_if.ovr_data[PD_PWM_B]    = enhanced_pwm_out_b;
            d_if.ovr_dir_en[PD_PWM_B]  = epwm_shutdown_tristate;
            d_if.ovr_dir[PD_PWM_B]     = 1'b1;
        end
        if (pwm_cd_en) begin
            d_if.ovr_data_en[PD_PWM_C] = 1'b1;
            d_if.ovr_data[PD_PWM_C]    = enhanced_pwm_out_c;
            d_if.ovr_dir_en[PD_PWM_C]  = epwm_shutdown_tristate;
            d_if.ovr_dir[PD_PWM_C]     = 1'b1;
            d_if.ovr_data_en[PD_PWM_D] = 1'b1;
            d_if.ovr_data[PD_PWM_D]    = enhanced_pwm_out_d;
            d_if.ovr_dir_en[PD_PWM_D]  = epwm_shutdown_tristate;
            d_if.ovr_dir[PD_PWM_D]     = 1'b1;
        end
    end

    // Third port overrides
    assign second_capture_compare_sel = r.cfg[CFG_SECOND_CAPTURE_COMPARE_BIT];

    always_comb begin
        c_if.tris        = r.c_dir;
        c_if.latch       = r.c_lat;
        c_if.ovr_dir_en  = 8'h00;
        c_if.ovr_dir     = 8'hFF;
        c_if.ovr_data_en = 8'h00;
        c_if.ovr_data    = r.c_lat;
        c_if.ovr_data_en[PC_SECOND_CAPTURE_COMPARE] = second_capture_compare_sel && second_capture_compare_out_en;
        c_if.ovr_data[PC_SECOND_CAPTURE_COMPARE]    = second_capture_compare_out;
        c_if.ovr_data_en[PC_CCP1] = ccp1_out_en;
        c_if.ovr_data[PC_CCP1]    = ccp1_out;
        if (ssp_spi_en) begin
            c_if.ovr_data_en[PC_SCK] = ssp_sck_master;
            c_if.ovr_data[PC_SCK]    = ssp_sck_out;
            c_if.ovr_data_en[PC_SDO] = 1'b1;
            c_if.ovr_data[PC_SDO]    = ssp_sdo;
        end
        if (ssp_i2c_en) begin
            // Bus lines only pull low; release means input
            c_if.ovr_dir_en[PC_SCK]  = 1'b1;
            c_if.ovr_dir[PC_SCK]     = ~ssp_scl_low;
            c_if.ovr_data_en[PC_SCK] = 1'b1;
            c_if.ovr_data[PC_SCK]    = 1'b0;
            c_if.ovr_dir_en[PC_SDA]  = 1'b1;
            c_if.ovr_dir[PC_SDA]     = ~ssp_sda_low;
            c_if.ovr_data_en[PC_SDA] = 1'b1;
            c_if.ovr_data[PC_SDA]    = 1'b0;
        end
        if (usart_en && !usart_sync) begin
            // Direction stays with software for the transmit pin
            c_if.ovr_data_en[PC_TX]  = 1'b1;
            c_if.ovr_data[PC_TX]     = usart_tx;
        end
        if (usart_en && usart_sync) begin
            c_if.ovr_dir_en[PC_TX]   = 1'b1;
            c_if.ovr_dir[PC_TX]      = ~usart_sync_master;
            c_if.ovr_data_en[PC_TX]  = usart_sync_master;
            c_if.ovr_data[PC_TX]     = usart_sync_clock_out;
            c_if.ovr_dir_en[PC_RX]   = usart_sync_data_drive;
            c_if.ovr_dir[PC_RX]      = 1'b0;
            c_if.ovr_data_en[PC_RX]  = usart_sync_data_drive;
            c_if.ovr_data[PC_RX]     = usart_sync_data_out;
        end
    end

    assign pd_out  = d_if.pad_out;
    assign pd_oe_n = d_if.pad_oe_n;
    assign pc_out  = c_if.pad_out;
    assign pc_oe_n = c_if.pad_oe_n;

    // Peripheral inputs from synchronised levels; SMBus buffer select from the I2C controls
    assign ssp_sck_in          = c_level[PC_SCK];
    assign ssp_sdi             = c_level[PC_SDA];
    assign i2c_sda_smbus_buf   = ssp_i2c_en && ssp_i2c_smbus_levels;
    assign usart_rx_in         = c_level[PC_RX];
    assign usart_sync_clock_in = c_level[PC_TX];
    assign ccp1_in             = c_level[PC_CCP1];
    assign second_capture_compare_in             = second_capture_compare_sel ? c_level[PC_SECOND_CAPTURE_COMPARE] : alt_sync_r[1];

    // Alternate capture pin lives here only for its mux
    assign alt_pin_port_b_bit3_out  = second_capture_compare_out;
    assign alt_pin_port_b_bit3_oe_n = ~(!second_capture_compare_sel && second_capture_compare_out_en);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alt_sync_r <= 2'h0;
        end else begin
            alt_sync_r <= {alt_sync_r[0], alt_pin_port_b_bit3_in};
        end
    end

    // Register slave; one write and one read outstanding
    always_comb begin
        n             = r;
        s_axi_awready = !r.awh && !r.bvalid;
        s_axi_wready  = !r.wh && !r.bvalid;
        s_axi_arready = !r.rvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            n.awh    = 1'b1;
            n.awaddr = s_axi_awaddr[7:0];
            n.awbad  = (s_axi_awaddr[31:8] != 24'h000000) || (s_axi_awaddr[1:0] != 2'h0);
        end
        if (s_axi_wvalid && s_axi_wready) begin
            n.wh     = 1'b1;
            n.wdata  = s_axi_wdata[7:0];
            n.wstrb0 = s_axi_wstrb[0];
        end
        if (r.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (r.awh && r.wh) begin
            n.awh    = 1'b0;
            n.wh     = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = RESP_OKAY;
            if (r.awbad) begin
                n.bresp = RESP_SLVERR;
            end else begin
                case (r.awaddr)
                    // Data writes land in the latch, as on real ports
                    OFF_D_DATA, OFF_D_LAT: if (r.wstrb0) n.d_lat = r.wdata;
                    OFF_D_DIR:  if (r.wstrb0) n.d_dir = r.wdata;
                    OFF_C_DATA, OFF_C_LAT: if (r.wstrb0) n.c_lat = r.wdata;
                    OFF_C_DIR:  if (r.wstrb0) n.c_dir = r.wdata;
                    OFF_E_DIR:  if (r.wstrb0) n.e_dir = r.wdata;
                    OFF_CFG:    if (r.wstrb0) n.cfg = r.wdata;
                    OFF_STAT:   n.bresp = RESP_OKAY;
                    default:    n.bresp = RESP_SLVERR;
                endcase
            end
        end
        if (r.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            n.rvalid = 1'b1;
            n.rresp  = RESP_OKAY;
            n.rdata  = 32'h00000000;
            if ((s_axi_araddr[31:8] != 24'h000000) || (s_axi_araddr[1:0] != 2'h0)) begin
                n.rresp = RESP_SLVERR;
            end else begin
                case (s_axi_araddr[7:0])
                    OFF_D_DATA: n.rdata = {24'h000000, d_level};
                    OFF_D_DIR:  n.rdata = {24'h000000, r.d_dir};
                    OFF_D_LAT:  n.rdata = {24'h000000, r.d_lat};
                    OFF_C_DATA: n.rdata = {24'h000000, c_level};
                    OFF_C_DIR:  n.rdata = {24'h000000, r.c_dir};
                    OFF_C_LAT:  n.rdata = {24'h000000, r.c_lat};
                    OFF_E_DIR:  n.rdata = {24'h000000, r.e_dir};
                    OFF_CFG:    n.rdata = {24'h000000, r.cfg};
                    OFF_STAT: begin
                        n.rdata[STAT_PSP_BIT] = psp_active;
                        n.rdata[STAT_TTL_BIT] = fourth_port_ttl_sel;
                        n.rdata[STAT_SMB_BIT] = i2c_sda_smbus_buf;
                    end
                    default:    n.rresp = RESP_SLVERR;
                endcase
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= REGS_RST;
        end else begin
            r <= n;
        end
    end

    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp  = r.bresp;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata  = r.rdata;
    assign s_axi_rresp  = r.rresp;

endmodule : bpo_port_top

// >>> bpo_ext_model.sv
// External circuit on one 8-bit port: reads driven pins, drives the rest.
// Assumes oe_n low means the block drives that pin.
`timescale 1ns/1ps
module bpo_ext_model (
    input  wire logic [7:0] out,
    input  wire logic [7:0] oe_n,
    input  wire logic [7:0] ext,
    output logic [7:0]      lvl
);
    // Contention ignored: the block's driver wins, as a strong push-pull would
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            lvl[i] = oe_n[i] ? ext[i] : out[i];
        end
    end
endmodule : bpo_ext_model

// >>> bpo_port_monitor.sv
// Checker for the port top: bus handshakes, reset release, pin overrides.
// Assumes binding onto bpo_port_top; sees only its ports.
`timescale 1ns/1ps
module bpo_port_monitor (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic [7:0] pd_out,
    input wire logic [7:0] pd_oe_n,
    input wire logic [7:0] pc_out,
    input wire logic [7:0] pc_oe_n,
    input wire logic [1:0] epwm_mode,
    input wire logic       enhanced_pwm_out_b,
    input wire logic       psp_active,
    input wire logic       fourth_port_ttl_sel,
    input wire logic       ssp_spi_en,
    input wire logic       ssp_sdo
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_ttl_follow: assert property (fourth_port_ttl_sel == psp_active)
        else $error("ttl select differs from parallel slave state");
    chk_pwm_no_psp: assert property (epwm_mode != 2'h0 |-> !psp_active)
        else $error("parallel slave active with dual or quad pwm");
    // Own disable: the pins must already be released while reset is held
    chk_reset_hiz: assert property (disable iff (1'h0) !aresetn |=> pd_oe_n == 8'hFF && pc_oe_n == 8'hFF)
        else $error("pins driven after reset");
    chk_pwm_b_pin: assert property ($past(aresetn) && $past(epwm_mode) != 2'h0 && !pd_oe_n[5]
        |-> pd_out[5] == $past(enhanced_pwm_out_b)) else $error("pwm b not on its pin");
    chk_sdo_pin: assert property ($past(aresetn) && $past(ssp_spi_en) && !pc_oe_n[5]
        |-> pc_out[5] == $past(ssp_sdo)) else $error("spi data out not on its pin");
    chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write answer late");
    chk_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    cover property (psp_active);
    cover property (s_axi_bvalid);
    cover property (ssp_spi_en && !pc_oe_n[5]);
endmodule : bpo_port_monitor
bind bpo_port_top bpo_port_monitor u_mon (.*);

// >>> testbench.sv
// Self-checking bench for the port: register bus, pin levels, overrides.
// Assumes external circuits drive every pin the block leaves at hi-z.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module testbench;
    import bpo_pkg::*;
    int seed = 32'h96b72dbd;
    int mismatches = 0;
    int n_checks = 0;
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [1:0] epwm_mode = '0, eb;
    logic [7:0] ext = '0, lat, dir, b, pw;
    logic epwm_shutdown_tristate = 0, enhanced_pwm_out_b = 0, enhanced_pwm_out_c = 0, enhanced_pwm_out_d = 0;
    logic psp_read_drive = 0, alt_pin_port_b_bit3_in = 0, ccp1_out_en = 0, ccp1_out = 0;
    logic second_capture_compare_out_en = 0, second_capture_compare_out = 0, ssp_spi_en = 0, ssp_sck_master = 0, ssp_sck_out = 0, ssp_sdo = 0;
    logic ssp_i2c_en = 0, ssp_scl_low = 0, ssp_sda_low = 0, ssp_i2c_smbus_levels = 0;
    logic usart_en = 0, usart_sync = 0, usart_sync_master = 0, usart_tx = 0;
    logic usart_sync_clock_out = 0, usart_sync_data_out = 0, usart_sync_data_drive = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [7:0] pd_in, pd_out, pd_oe_n, pc_in, pc_out, pc_oe_n, psp_write_data;
    logic alt_pin_port_b_bit3_out, alt_pin_port_b_bit3_oe_n, psp_active, fourth_port_ttl_sel;
    logic ssp_sck_in, ssp_sdi, i2c_sda_smbus_buf, usart_rx_in, usart_sync_clock_in, ccp1_in, second_capture_compare_in;
    logic [41:0] rq[$];
    logic [1:0] bq[$];
    logic [41:0] en;
    logic [15:0] rst_tab [7] = '{{OFF_D_DIR, RST_DIR}, {OFF_D_LAT, RST_LAT}, {OFF_C_DIR, RST_DIR},
        {OFF_C_LAT, RST_LAT}, {OFF_E_DIR, RST_E_DIR}, {OFF_CFG, RST_CFG}, {OFF_STAT, 8'h00}};

    bpo_port_top u_dut (.*);
    bpo_ext_model u_xd (.out(pd_out), .oe_n(pd_oe_n), .ext(ext), .lvl(pd_in));
    bpo_ext_model u_xc (.out(pc_out), .oe_n(pc_oe_n), .ext(ext), .lvl(pc_in));

    always #2 aclk = ~aclk;

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    // Two synchroniser flops plus the pad register, with margin
    task automatic settle;
        repeat (4) @(posedge aclk);
    endtask : settle

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e = RESP_OKAY);
        logic [31:0] r;
        r = $random(seed);
        bq.push_back(e);
        @(posedge aclk);
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= {r[31:8], d};
        s_axi_wstrb <= {r[3:1], 1'h1};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r = RESP_OKAY);
        rq.push_back({a, r, 24'h0, e});
        @(posedge aclk);
        s_axi_araddr <= {24'h0, a};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
    endtask : rd

    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            en = rq.pop_front();
            `CHK($sformatf("rd_%0h", en[41:34]), en[33:0], {s_axi_rresp, s_axi_rdata})
        end
        if (s_axi_bvalid && s_axi_bready) begin
            eb = bq.pop_front();
            `CHK("bresp", eb, s_axi_bresp)
        end
    end

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        `CHK("oe_n_rst", 16'hFFFF, {pd_oe_n, pc_oe_n})
        foreach (rst_tab[i]) rd(rst_tab[i][15:8], rst_tab[i][7:0]);
        rd(8'h24, 8'h00, RESP_SLVERR);
        wr(8'h24, 8'h5A, RESP_SLVERR);
        for (int i = 0; i < 8; i++) begin
            b = i[0] ? OFF_C_DATA : OFF_D_DATA;
            lat = 8'($random(seed));
            dir = 8'($random(seed));
            ext <= 8'($random(seed));
            wr(i[1] ? b : b + 8'h08, lat);
            wr(b + 8'h04, dir);
            settle();
            rd(b + 8'h08, lat);
            rd(b + 8'h04, dir);
            rd(b, (lat & ~dir) | (ext & dir));
            `CHK("oe_n", dir, i[0] ? pc_oe_n : pd_oe_n)
        end
        wr(OFF_E_DIR, 8'h10);
        settle();
        `CHK("psp_in", {8'hFF, ext}, {pd_oe_n, psp_write_data})
        psp_read_drive <= 1'h1;
        settle();
        `CHK("psp_drv", 8'h00, pd_oe_n)
        psp_read_drive <= 1'h0;
        for (int m = 0; m < 4; m++) begin
            epwm_mode <= 2'(m);
            settle();
            `CHK("psp_active", m == 0, psp_active)
            rd(OFF_STAT, (m == 0) ? 8'h03 : 8'h00);
        end
        wr(OFF_E_DIR, 8'h00);
        wr(OFF_D_DIR, 8'h1F);
        pw = 8'($random(seed));
        {enhanced_pwm_out_d, enhanced_pwm_out_c, enhanced_pwm_out_b} <= pw[2:0];
        ext <= 8'($random(seed));
        settle();
        rd(OFF_D_DATA, {pw[2:0], ext[4:0]});
        epwm_shutdown_tristate <= 1'h1;
        settle();
        `CHK("pwm_tri", 8'hFF, pd_oe_n)
        epwm_shutdown_tristate <= 1'h0;
        wr(OFF_C_LAT, 8'hFF);
        wr(OFF_C_DIR, 8'h00);
        ssp_spi_en <= 1'h1;
        ssp_sck_master <= 1'h1;
        ccp1_out_en <= 1'h1;
        usart_en <= 1'h1;
        usart_sync <= 1'h1;
        usart_sync_master <= 1'h1;
        settle();
        rd(OFF_C_DATA, 8'h93);
        ssp_spi_en <= 1'h0;
        ssp_sck_master <= 1'h0;
        ssp_i2c_en <= 1'h1;
        ssp_sda_low <= 1'h1;
        ssp_i2c_smbus_levels <= 1'h1;
        usart_sync_master <= 1'h0;
        ccp1_out_en <= 1'h0;
        wr(OFF_C_DIR, 8'h80);
        settle();
        rd(OFF_C_DATA, {ext[7], ext[6], 2'h2, ext[3], 3'h7});
        rd(OFF_STAT, 8'h04);
        `CHK("ck_rx_in", {ext[6], ext[7]}, {usart_sync_clock_in, usart_rx_in})
        `CHK("c_ins", {ext[3], 2'h1}, {ssp_sck_in, ssp_sdi, ccp1_in})
        usart_sync_data_drive <= 1'h1;
        usart_sync_data_out <= ~ext[7];
        settle();
        `CHK("dt_pin", {1'h0, ~ext[7], ~ext[7]}, {pc_oe_n[7], pc_out[7], usart_rx_in})
        usart_sync <= 1'h0;
        usart_tx <= 1'h0;
        second_capture_compare_out_en <= 1'h1;
        second_capture_compare_out <= 1'h1;
        settle();
        `CHK("tx_pin", 2'h0, {pc_oe_n[6], pc_out[6]})
        `CHK("second_capture_compare_dflt", 2'h3, {alt_pin_port_b_bit3_oe_n, second_capture_compare_in})
        alt_pin_port_b_bit3_in <= pw[3];
        wr(OFF_CFG, 8'h00);
        settle();
        `CHK("second_capture_compare_alt", {2'h1, pw[3]}, {alt_pin_port_b_bit3_oe_n, alt_pin_port_b_bit3_out, second_capture_compare_in})
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        settle();
        `CHK("pd_oe_n", 8'hFF, pd_oe_n)
        rd(OFF_CFG, RST_CFG);
        settle();
        close_out();
    end

    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        close_out();
    end
endmodule : testbench
